/* core/aemc_consts.vh */
`ifndef AEMC_CONSTS_VH
`define AEMC_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define AEMC_ADDR_W 12
`define AEMC_OFF_CORR_STATUS 12'h110
`define AEMC_OFF_CORR_MASK 12'h114
`define AEMC_OFF_CTRL 12'h118
`define AEMC_OFF_HDR_LOG1 12'h11c
`define AEMC_OFF_MEM_CTRL 12'h140
`define AEMC_OFF_IRQ_STATUS 12'h144
`define AEMC_OFF_IRQ_MASK 12'h148

// ----------------------------------------
// Correctable mask / status layout
// ----------------------------------------
`define AEMC_CORR_IMPL 32'h800031c1
`define AEMC_CORR_MASK_RST 32'h00002000
`define AEMC_BIT_RCV 0
`define AEMC_BIT_BAD_PKT 6
`define AEMC_BIT_BAD_LINK 7
`define AEMC_BIT_ROLLOVER 8
`define AEMC_BIT_REPLAY_TO 12
`define AEMC_BIT_ADVISORY 13
`define AEMC_BIT_SBE 31

// ----------------------------------------
// Control register layout
// ----------------------------------------
`define AEMC_FEP_HI 4
`define AEMC_FEP_LO 0
`define AEMC_BIT_GEN_CAP 5
`define AEMC_BIT_GEN_EN 6
`define AEMC_BIT_CHK_CAP 7
`define AEMC_BIT_CHK_EN 8
`define AEMC_GEN_CAP_RST 1'h1
`define AEMC_GEN_EN_RST 1'h0
`define AEMC_CHK_CAP_RST 1'h1
`define AEMC_CHK_EN_RST 1'h0
`define AEMC_FEP_RST 5'h00

// ----------------------------------------
// Memory error control and interrupts
// ----------------------------------------
`define AEMC_BIT_SBE_REPORT_EN 0
`define AEMC_BIT_CAP_LOCK 1
`define AEMC_IRQ_W 2
`define AEMC_IRQ_CORR 0
`define AEMC_IRQ_FIRST 1

`endif

/* core/aemc_sticky_flags.v */
`timescale 1ns/1ps

// Bank of W1C flags; a set in the clearing cycle wins
module aemc_sticky_flags #(
	parameter W = 1
)(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	input wire soft_clr,
	// Flag control
	input wire [W-1:0] set,
	input wire [W-1:0] clr,
	// State
	output reg [W-1:0] q_ff
);

	wire [W-1:0] nxt_q;

	assign nxt_q = soft_clr ? set : ((q_ff & ~clr) | set);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q_ff <= {W{1'b0}};
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

endmodule

/* core/aemc_top.v */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "aemc_consts.vh"

// Contract
// RL1: A set correctable mask bit stops reporting of its event upstream.
// RL2: Advisory non-fatal mask bit resets to one; other mask bits reset to zero.
// RL3: Single-bit mask acts only while single-bit reporting enable is set.
// RL4: Masked correctable event is not logged, leaves pointer, sends no report.
// RL5: Single-bit mask leaves the single-bit status bit recording the event.
// RL6: With reporting enable clear, single-bit mask reads zero, ignores writes.
// RL7: Bits 4:0 of control hold uncorrectable status index of first error.
// RL8: Control bit 5 is write-lockable CRC generation capable, default one.
// RL9: Control bit 6 enables CRC generation on outgoing packets, default zero.
// RL10: Control bit 7 is CRC checking capable, default one.
// RL11: Control bit 8 enables CRC checking of received packets, default zero.
// RL12: Read-only header log holds first header word of first uncorrectable error.
// RL13: Single-bit status sets on any memory single-bit error while enabled.
// RL14: Reserved and read-only fields ignore writes; reserved fields read zero.
module aemc_top (
	// Clock and power-on reset
	input wire pclk,
	input wire presetn,
	// Ordinary reset, clears non-sticky state
	input wire soft_rst,
	// APB slave
	input wire [`AEMC_ADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Correctable events, one pulse per bit at status positions
	input wire [31:0] corr_evt,
	// Uncorrectable error report
	input wire unc_evt,
	input wire [4:0] unc_index,
	input wire [31:0] unc_hdr_dw0,
	input wire unc_log_release,
	// Upstream reporting and CRC controls
	output reg corr_report,
	output reg crc_gen_capable,
	output reg crc_gen_enable,
	output reg crc_check_capable,
	output reg crc_check_enable,
	// Interrupt
	output reg irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [31:0] mask_ff;
	reg fep_valid_ff;
	reg [4:0] fep_ff;
	reg [31:0] hdr_log_ff;
	reg gen_cap_ff;
	reg chk_cap_ff;
	reg sbe_report_en_ff;
	reg cap_lock_ff;
	reg [`AEMC_IRQ_W-1:0] irq_mask_ff;
	wire [31:0] corr_status;
	wire [`AEMC_IRQ_W-1:0] irq_status;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire setup_phase;
	wire wr_commit;
	reg hit;
	reg [31:0] rd_word;

	assign setup_phase = psel & ~penable;
	// Write lands at the edge where pready is sampled high
	assign wr_commit = psel & penable & pready & pwrite & ~pslverr;

	wire wr_status = wr_commit && (paddr == `AEMC_OFF_CORR_STATUS);
	wire wr_mask = wr_commit && (paddr == `AEMC_OFF_CORR_MASK);
	wire wr_ctrl = wr_commit && (paddr == `AEMC_OFF_CTRL);
	wire wr_mem = wr_commit && (paddr == `AEMC_OFF_MEM_CTRL);
	wire wr_irq_st = wr_commit && (paddr == `AEMC_OFF_IRQ_STATUS);
	wire wr_irq_mask = wr_commit && (paddr == `AEMC_OFF_IRQ_MASK);

	// ----------------------------------------
	// Effective mask
	// ----------------------------------------
	wire [31:0] sbe_gate;
	wire [31:0] eff_mask;

	// Single-bit mask counts only while reporting is enabled
	assign sbe_gate = {sbe_report_en_ff, 31'h0} | 32'h7fffffff; // [RL3]
	assign eff_mask = mask_ff & sbe_gate & `AEMC_CORR_IMPL; // [RL3]

	// ----------------------------------------
	// Correctable event handling
	// ----------------------------------------
	wire [31:0] evt_gate;
	wire [31:0] corr_set;
	wire [31:0] unmasked;

	// Single-bit events only recorded while reporting is enabled
	assign evt_gate = {sbe_report_en_ff, 31'h0} | 32'h7fffffff; // [RL13]
	// Status records every implemented, enabled event whatever the mask says
	assign corr_set = corr_evt & `AEMC_CORR_IMPL & evt_gate; // [RL5] [RL13]
	// Masked events neither reported nor counted as logged
	assign unmasked = corr_set & ~eff_mask; // [RL1] [RL4]

	// Status is sticky: ordinary reset leaves it alone
	aemc_sticky_flags #(
		.W(32)
	) u_corr_status (
		.pclk(pclk),
		.presetn(presetn),
		.soft_clr(1'b0),
		.set(corr_set),
		.clr(wr_status ? (pwdata & `AEMC_CORR_IMPL) : 32'h0), // [RL14]
		.q_ff(corr_status)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			corr_report <= 1'b0;
		end
		else
		begin
			corr_report <= |unmasked; // [RL1] [RL4]
		end
	end

	// ----------------------------------------
	// First uncorrectable error capture
	// ----------------------------------------
	wire capture;

	// Only the first report is kept until the log is released
	assign capture = unc_evt & (~fep_valid_ff | unc_log_release);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fep_valid_ff <= 1'b0;
			fep_ff <= `AEMC_FEP_RST;
			hdr_log_ff <= 32'h0;
		end
		else
		begin
			if (capture)
			begin
				fep_valid_ff <= 1'b1;
				fep_ff <= unc_index; // [RL7]
				hdr_log_ff <= unc_hdr_dw0; // [RL12]
			end
			else if (unc_log_release)
			begin
				fep_valid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Sticky mask and enables
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_ff <= `AEMC_CORR_MASK_RST; // [RL2]
			crc_gen_enable <= `AEMC_GEN_EN_RST; // [RL9]
			crc_check_enable <= `AEMC_CHK_EN_RST; // [RL11]
			sbe_report_en_ff <= 1'b0;
		end
		else
		begin
			if (wr_mask)
			begin
				// Single-bit mask frozen while reporting is off
				mask_ff <= (pwdata & `AEMC_CORR_IMPL & 32'h7fffffff) |
					{sbe_report_en_ff ? pwdata[`AEMC_BIT_SBE] : mask_ff[`AEMC_BIT_SBE], 31'h0}; // [RL6] [RL14]
			end
			if (wr_ctrl)
			begin
				crc_gen_enable <= pwdata[`AEMC_BIT_GEN_EN]; // [RL9]
				crc_check_enable <= pwdata[`AEMC_BIT_CHK_EN]; // [RL11]
			end
			if (wr_mem)
			begin
				sbe_report_en_ff <= pwdata[`AEMC_BIT_SBE_REPORT_EN];
			end
		end
	end

	// ----------------------------------------
	// Non-sticky capability bits and lock
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gen_cap_ff <= `AEMC_GEN_CAP_RST; // [RL8]
			chk_cap_ff <= `AEMC_CHK_CAP_RST; // [RL10]
			cap_lock_ff <= 1'b0;
			irq_mask_ff <= {`AEMC_IRQ_W{1'b0}};
		end
		else if (soft_rst)
		begin
			gen_cap_ff <= `AEMC_GEN_CAP_RST; // [RL8]
			chk_cap_ff <= `AEMC_CHK_CAP_RST; // [RL10]
			cap_lock_ff <= 1'b0;
			irq_mask_ff <= {`AEMC_IRQ_W{1'b0}};
		end
		else
		begin
			// Capability bits writable only until locked
			if (wr_ctrl && !cap_lock_ff)
			begin
				gen_cap_ff <= pwdata[`AEMC_BIT_GEN_CAP]; // [RL8]
				chk_cap_ff <= pwdata[`AEMC_BIT_CHK_CAP]; // [RL10]
			end
			if (wr_mem)
			begin
				cap_lock_ff <= pwdata[`AEMC_BIT_CAP_LOCK];
			end
			if (wr_irq_mask)
			begin
				irq_mask_ff <= pwdata[`AEMC_IRQ_W-1:0];
			end
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_gen_capable <= `AEMC_GEN_CAP_RST;
			crc_check_capable <= `AEMC_CHK_CAP_RST;
		end
		else
		begin
			crc_gen_capable <= gen_cap_ff;
			crc_check_capable <= chk_cap_ff;
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	wire [`AEMC_IRQ_W-1:0] irq_set;

	assign irq_set = {capture, |unmasked};

	aemc_sticky_flags #(
		.W(`AEMC_IRQ_W)
	) u_irq_status (
		.pclk(pclk),
		.presetn(presetn),
		.soft_clr(soft_rst),
		.set(irq_set),
		.clr(wr_irq_st ? pwdata[`AEMC_IRQ_W-1:0] : {`AEMC_IRQ_W{1'b0}}),
		.q_ff(irq_status)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(irq_status & irq_mask_ff);
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @*
	begin
		hit = 1'b1;
		rd_word = 32'h0;
		case (paddr)
			`AEMC_OFF_CORR_STATUS:
			begin
				rd_word = corr_status & evt_gate; // [RL14]
			end
			`AEMC_OFF_CORR_MASK:
			begin
				rd_word = eff_mask; // [RL6] [RL14]
			end
			`AEMC_OFF_CTRL:
			begin
				rd_word[`AEMC_FEP_HI:`AEMC_FEP_LO] = fep_ff; // [RL7]
				rd_word[`AEMC_BIT_GEN_CAP] = gen_cap_ff;
				rd_word[`AEMC_BIT_GEN_EN] = crc_gen_enable;
				rd_word[`AEMC_BIT_CHK_CAP] = chk_cap_ff;
				rd_word[`AEMC_BIT_CHK_EN] = crc_check_enable;
			end
			`AEMC_OFF_HDR_LOG1:
			begin
				rd_word = hdr_log_ff; // [RL12]
			end
			`AEMC_OFF_MEM_CTRL:
			begin
				rd_word[`AEMC_BIT_SBE_REPORT_EN] = sbe_report_en_ff;
				rd_word[`AEMC_BIT_CAP_LOCK] = cap_lock_ff;
			end
			`AEMC_OFF_IRQ_STATUS:
			begin
				rd_word[`AEMC_IRQ_W-1:0] = irq_status;
			end
			`AEMC_OFF_IRQ_MASK:
			begin
				rd_word[`AEMC_IRQ_W-1:0] = irq_mask_ff;
			end
			default:
			begin
				hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// APB answer: one wait-free access cycle
	// ----------------------------------------
	// Data sampled in setup so prdata comes from a flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else if (setup_phase)
		begin
			pready <= 1'b1;
			pslverr <= ~hit;
			prdata <= (hit && !pwrite) ? rd_word : 32'h0;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
	end

endmodule

/* dv/aemc_root_model.sv */
`timescale 1ns/1ps
// ----
// Upstream end: tallies error reports taken in
// ----
module aemc_root_model (
	input wire pclk,
	input wire presetn,
	input wire corr_report,
	output int report_cnt
);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			report_cnt <= 0;
		else if (corr_report)
			report_cnt <= report_cnt + 1;
	end
endmodule

/* dv/aemc_checker.sv */
`timescale 1ns/1ps
// ----
// Register and report checks
// ----
module aemc_checker (
	input wire pclk,
	input wire presetn,
	input wire soft_rst,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [31:0] corr_evt,
	input wire corr_report,
	input wire crc_gen_capable,
	input wire crc_gen_enable,
	input wire crc_check_capable,
	input wire crc_check_enable
);
	reg [31:0] mask_ff;
	wire acc = psel && penable && pready;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bit 31 left out, it hides behind its enable
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_ff <= 32'h00002000;
		else if (acc && pwrite && paddr == 12'h114)
			mask_ff <= pwdata & 32'h000031c1;
	end
	sequence s_ctrl_wr;
		acc && pwrite && paddr == 12'h118;
	endsequence
	sequence s_rd(a);
		acc && !pwrite && paddr == a;
	endsequence
	a_unmasked_report: assert property (|(corr_evt & 32'h000031c1 & ~mask_ff) |=> corr_report)
		else $error("report missing");
	a_masked_silent: assert property (corr_evt != 0 && (corr_evt & ~mask_ff) == 0 |=> !corr_report)
		else $error("masked event reported");
	a_mask_readback: assert property (s_rd(12'h114) |-> prdata[30:0] == mask_ff[30:0])
		else $error("mask read wrong");
	a_ctrl_reserved: assert property (s_rd(12'h118) |-> prdata[31:9] == 23'h0)
		else $error("ctrl reserved set");
	a_caps_follow: assert property (s_rd(12'h118) |=> crc_gen_capable == $past(prdata[5])
		&& crc_check_capable == $past(prdata[7]))
		else $error("caps differ");
	a_enable_write: assert property (s_ctrl_wr |=> crc_gen_enable == $past(pwdata[6])
		&& crc_check_enable == $past(pwdata[8]))
		else $error("enable wrong");
	a_unmapped_err: assert property (acc && paddr == 12'h200 |-> pslverr && prdata == 32'h0)
		else $error("unmapped answered");
	a_caps_soft: assert property (soft_rst |-> ##2 crc_gen_capable && crc_check_capable)
		else $error("caps not restored");
endmodule

bind aemc_top aemc_checker chk (.*);

/* dv/aer_correctable_mask_control_tb.sv */
`timescale 1ns/1ps
module aer_correctable_mask_control_tb;
	reg pclk = 0, presetn = 0, soft_rst = 0, psel = 0, penable = 0, pwrite = 0;
	reg unc_evt = 0, unc_log_release = 0, err;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0, corr_evt = 32'h0, unc_hdr_dw0 = 32'h0, rd;
	reg [4:0] unc_index = 5'h0;
	wire [31:0] prdata;
	wire pready, pslverr, corr_report, irq;
	wire crc_gen_capable, crc_gen_enable, crc_check_capable, crc_check_enable;
	int failures = 0, tests_run = 0, report_cnt, c0;
	int bits[6] = '{0, 6, 7, 8, 12, 13};
	always #20 pclk = ~pclk;
	aemc_top uut (.*);
	aemc_root_model rc (.*);
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// ----
	// APB master, waits on pready
	// ----
	task apb(input [11:0] a, input w, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (!pready)
		begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdc(input [11:0] a, input [31:0] exp, input string what);
		apb(a, 0, 0);
		chk(rd, exp, what);
	endtask
	task evt(input int b);
		@(posedge pclk);
		corr_evt <= 32'h1 << b;
		@(posedge pclk);
		corr_evt <= 0;
		repeat (2) @(posedge pclk);
	endtask
	task unc(input [4:0] i, input [31:0] h, input r);
		@(posedge pclk);
		unc_evt <= 1;
		unc_index <= i;
		unc_hdr_dw0 <= h;
		unc_log_release <= r;
		@(posedge pclk);
		unc_evt <= 0;
		unc_log_release <= 0;
	endtask
	task stop_test;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#400000;
		failures++;
		stop_test;
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		rdc(12'h114, 32'h00002000, "mask rst");
		rdc(12'h118, 32'h000000a0, "ctrl rst");
		apb(12'h114, 1, 32'hffffffff);
		rdc(12'h114, 32'h000031c1, "mask rsvd");
		foreach (bits[i])
		begin
			apb(12'h114, 1, 0);
			c0 = report_cnt;
			evt(bits[i]);
			chk(report_cnt, c0 + 1, "report");
			apb(12'h114, 1, 32'h1 << bits[i]);
			evt(bits[i]);
			chk(report_cnt, c0 + 1, "masked");
			rdc(12'h110, 32'h1 << bits[i], "status");
			apb(12'h110, 1, 32'hffffffff);
		end
		apb(12'h114, 1, 32'h80000000);
		rdc(12'h114, 0, "sbe off");
		evt(31);
		rdc(12'h110, 0, "sbe off evt");
		apb(12'h140, 1, 1);
		apb(12'h114, 1, 32'h80000000);
		rdc(12'h114, 32'h80000000, "sbe mask");
		c0 = report_cnt;
		evt(31);
		chk(report_cnt, c0, "sbe masked");
		rdc(12'h110, 32'h80000000, "sbe status");
		apb(12'h118, 1, 32'hffffffff);
		rdc(12'h118, 32'h000001e0, "ctrl set");
		chk({crc_gen_enable, crc_check_enable}, 2'b11, "crc en");
		apb(12'h140, 1, 32'h3);
		apb(12'h118, 1, 0);
		rdc(12'h118, 32'h000000a0, "locked");
		apb(12'h140, 1, 32'h1);
		apb(12'h118, 1, 0);
		rdc(12'h118, 0, "caps clr");
		@(posedge pclk);
		soft_rst <= 1;
		@(posedge pclk);
		soft_rst <= 0;
		repeat (2) @(posedge pclk);
		chk({crc_gen_capable, crc_check_capable}, 2'b11, "caps");
		rdc(12'h114, 32'h80000000, "sticky");
		unc(5, 32'h12345678, 0);
		rdc(12'h118, 32'h000000a5, "ptr");
		rdc(12'h11c, 32'h12345678, "hdr");
		unc(9, 32'h9abcdef0, 0);
		apb(12'h11c, 1, 32'hffffffff);
		rdc(12'h11c, 32'h12345678, "hdr held");
		unc(9, 32'h9abcdef0, 1);
		rdc(12'h118, 32'h000000a9, "ptr new");
		// Interrupt: raise, mask, clear
		apb(12'h144, 1, 32'h3);
		apb(12'h148, 1, 32'h1);
		apb(12'h114, 1, 0);
		evt(0);
		chk(irq, 1, "irq");
		apb(12'h148, 1, 0);
		repeat (2) @(posedge pclk);
		chk(irq, 0, "irq mask");
		apb(12'h144, 1, 32'h1);
		apb(12'h148, 1, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 0, "irq clr");
		apb(12'h200, 0, 0);
		chk(err, 1, "unmapped");
		stop_test;
	end
endmodule
